// ---- gpcr_axil.sv ----
// axi4-lite slave front end: one read in flight; a second write is taken in while a write response waits
`timescale 1ns/1ns
module gpcr_axil (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // write channels
  input  wire logic [gpcr_pkg::AW-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // read channels
  input  wire logic [gpcr_pkg::AW-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // core side
  output logic                       wr_go,
  output logic [gpcr_pkg::AW-1:0]    wr_addr,
  output logic [31:0]                wr_data,
  output logic [3:0]                 wr_strb,
  input  wire logic                  wr_ok,
  output logic                       rd_go,
  output logic [gpcr_pkg::AW-1:0]    rd_addr,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_ok
);
  gpcr_pkg::gpcr_axil_t st_ff;
  gpcr_pkg::gpcr_axil_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    wr_go  = st_ff.aw_full && st_ff.w_full && !st_ff.bvalid;
    rd_go  = arvalid && st_ff.arready;
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_full = 1'b1;
      nxt_st.w_data = wdata;
      nxt_st.w_strb = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_ok ? gpcr_pkg::RESP_OKAY : gpcr_pkg::RESP_SLVERR;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_ok ? rd_data : gpcr_pkg::ZERO_WORD;
      nxt_st.rresp  = rd_ok ? gpcr_pkg::RESP_OKAY : gpcr_pkg::RESP_SLVERR;
    end
    nxt_st.awready = !nxt_st.aw_full;
    nxt_st.wready  = !nxt_st.w_full;
    nxt_st.arready = !nxt_st.rvalid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awready;
  assign wready  = st_ff.wready;
  assign bvalid  = st_ff.bvalid;
  assign bresp   = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid  = st_ff.rvalid;
  assign rdata   = st_ff.rdata;
  assign rresp   = st_ff.rresp;
  assign wr_addr = st_ff.aw_addr;
  assign wr_data = st_ff.w_data;
  assign wr_strb = st_ff.w_strb;
  assign rd_addr = araddr;
endmodule : gpcr_axil

// ---- gpcr_pins.sv ----
// far-side model: pad levels and event link source
`timescale 1ns/1ns
module gpcr_pins (
  // clock
  input  wire logic        clk,
  // pads
  input  wire logic [95:0] pin_out,
  input  wire logic [95:0] pin_oe,
  input  wire logic [95:0] ext_lvl,
  output logic      [95:0] pin_in,
  // event link
  input  wire logic [5:0]  ev_req,
  input  wire logic [95:0] ev_dat,
  output logic      [5:0]  ev_pulse,
  output logic      [95:0] ev_bus
);
  // driven pads show the output, others the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  initial begin
    ev_pulse = 6'h00;
    ev_bus = 96'h0;
  end
  // pulse repeats ev_req one cycle later, as long as it is held; data bus toggles when no pulse is offered
  always @(posedge clk) begin
    ev_pulse <= ev_req;
    ev_bus <= (|ev_req) ? ev_dat : ~ev_bus;
  end
endmodule : gpcr_pins

// ---- gpcr_pkg.sv ----
// constants and types shared by the port control register block
package gpcr_pkg;
  localparam int NPORT = 6;
  localparam int PINS  = 16;
  localparam int AW    = 12;
  localparam int HALF  = 16;

  // register map: one group per port, then one word per pin function select
  localparam logic [AW-1:0] PORT_STRIDE = 12'h020;
  localparam logic [AW-1:0] PORT_SPAN   = 12'h0C0;
  localparam logic [AW-1:0] OFS_DIR_OUT = 12'h000;
  localparam logic [AW-1:0] OFS_INPUT   = 12'h004;
  localparam logic [AW-1:0] OFS_SW_SC   = 12'h008;
  localparam logic [AW-1:0] OFS_EVT_SC  = 12'h00C;
  localparam logic [AW-1:0] PFS_BASE    = 12'h100;
  localparam logic [AW-1:0] PFS_LAST    = 12'h27C;

  // function select word fields
  localparam int PFS_ODR_BIT = 0;
  localparam int PFS_PIN_BIT = 1;
  localparam int PFS_DIR_BIT = 2;
  localparam int PFS_PMR_BIT = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // which pins exist on each port (port 5 carries eight pins)
  localparam logic [NPORT-1:0][PINS-1:0] PIN_EXIST = {
    16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  localparam logic [NPORT*PINS-1:0] ZERO_PINS = '0;
  localparam logic [31:0]           ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    GPCR_SEL_NONE,
    GPCR_SEL_DIR_OUT,
    GPCR_SEL_INPUT,
    GPCR_SEL_SW_SC,
    GPCR_SEL_EVT_SC,
    GPCR_SEL_PFS
  } gpcr_sel_t;

  typedef struct packed {
    logic [NPORT-1:0][PINS-1:0] odr;
    logic [NPORT-1:0][PINS-1:0] dir;
    logic [NPORT-1:0][PINS-1:0] eos;
    logic [NPORT-1:0][PINS-1:0] eor;
    logic [NPORT-1:0][PINS-1:0] peripheral_mode_bit;
    logic [NPORT-1:0][PINS-1:0] eid;
    logic [NPORT-1:0][PINS-1:0] oe;
  } gpcr_core_t;

  typedef struct packed {
    logic          aw_full;
    logic [AW-1:0] aw_addr;
    logic          w_full;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } gpcr_axil_t;
endpackage : gpcr_pkg

// ---- gpcr_props.sv ----
// assertion checker for the port control register block
`timescale 1ns/1ns
module gpcr_props (
  // clock and reset
  input wire logic                    SYS_CLK,
  input wire logic                    SYS_RST,
  // bus
  input wire logic [gpcr_pkg::AW-1:0] S_AXI_AWADDR,
  input wire logic                    S_AXI_AWVALID,
  input wire logic                    S_AXI_AWREADY,
  input wire logic [31:0]             S_AXI_WDATA,
  input wire logic [3:0]              S_AXI_WSTRB,
  input wire logic                    S_AXI_WVALID,
  input wire logic                    S_AXI_WREADY,
  input wire logic                    S_AXI_BVALID,
  input wire logic [gpcr_pkg::AW-1:0] S_AXI_ARADDR,
  input wire logic                    S_AXI_ARVALID,
  input wire logic                    S_AXI_ARREADY,
  input wire logic [31:0]             S_AXI_RDATA,
  input wire logic [1:0]              S_AXI_RRESP,
  input wire logic                    S_AXI_RVALID,
  // pins and events
  input wire logic [95:0]             GPIO_OUT,
  input wire logic [95:0]             GPIO_OE,
  input wire logic [5:0]              PORT_EVENT_PULSE
);
  logic [gpcr_pkg::AW-1:0] aw_ff, ar_ff;
  logic [31:0]             wd_ff;
  logic [3:0]              ws_ff;
  logic [15:0]             eos_ff, lm, hm;
  assign lm = {{8{ws_ff[1]}}, {8{ws_ff[0]}}};
  assign hm = {{8{ws_ff[3]}}, {8{ws_ff[2]}}};
  // capture accepted requests and the event-set bits of port 0
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_ff  <= '0;
      ar_ff  <= '0;
      wd_ff  <= 32'h0;
      ws_ff  <= 4'h0;
      eos_ff <= 16'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_ff <= S_AXI_AWADDR;
      if (S_AXI_ARVALID && S_AXI_ARREADY) ar_ff <= S_AXI_ARADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd_ff <= S_AXI_WDATA;
        ws_ff <= S_AXI_WSTRB;
      end
      if ($rose(S_AXI_BVALID) && aw_ff == 12'h00C) eos_ff <= (eos_ff & ~lm) | (wd_ff[15:0] & lm);
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // write to a port 0 word just applied, no event at that edge
  sequence s_applied(logic [11:0] a);
    $rose(S_AXI_BVALID) && aw_ff == a && !$past(PORT_EVENT_PULSE[0]);
  endsequence
  property p_sw_set;
    s_applied(12'h008) |-> (GPIO_OUT[15:0] & wd_ff[15:0] & lm) == (wd_ff[15:0] & lm);
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("set write missed output bits");
  property p_sw_clr;
    s_applied(12'h008) |-> (GPIO_OUT[15:0] & wd_ff[31:16] & hm & ~(wd_ff[15:0] & lm)) == 16'h0;
  endproperty
  a_sw_clr: assert property (p_sw_clr) else $error("clear write left bits high");
  property p_out_wr;
    s_applied(12'h000) |-> ((GPIO_OUT[15:0] ^ wd_ff[31:16]) & hm) == 16'h0;
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("output half not written");
  property p_lane_keep;
    s_applied(12'h000) |-> ((GPIO_OUT[15:0] ^ $past(GPIO_OUT[15:0])) & ~hm) == 16'h0;
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("disabled lane changed");
  property p_oe_dir;
    s_applied(12'h000) |-> (GPIO_OE[15:0] & ~wd_ff[15:0] & lm) == 16'h0;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("input pin still driven");
  property p_missing;
    GPIO_OUT[95:88] == 8'h00 && GPIO_OE[95:88] == 8'h00;
  endproperty
  a_missing: assert property (p_missing) else $error("missing pin driven");
  property p_evt_set;
    PORT_EVENT_PULSE[0] |=> $rose(S_AXI_BVALID) || (GPIO_OUT[15:0] & eos_ff) == eos_ff;
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event did not set outputs");
  property p_wo_read;
    $rose(S_AXI_RVALID) && ar_ff[4:0] == 5'h08 && ar_ff < 12'h0C0 |-> S_AXI_RDATA == 32'h0;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("set/clear word read nonzero");
  property p_pfs_ok;
    $rose(S_AXI_RVALID) && ar_ff >= 12'h100 && ar_ff <= 12'h27C && ar_ff[1:0] == 2'h0
      |-> S_AXI_RRESP == 2'h0;
  endproperty
  a_pfs_ok: assert property (p_pfs_ok) else $error("function select read refused");
endmodule : gpcr_props

bind gpcr_top gpcr_props u_props (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
  .PORT_EVENT_PULSE(PORT_EVENT_PULSE));

// ---- gpcr_sync.sv ----
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module gpcr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpcr_sync_t;

  gpcr_sync_t st_ff;
  gpcr_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule : gpcr_sync

// ---- gpcr_top.sv ----
// general-purpose port control registers: six ports, five of sixteen pins and port 5 of eight
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module gpcr_top (
  // clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  // axi4-lite write channels
  input  wire logic [gpcr_pkg::AW-1:0] S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  // axi4-lite read channels
  input  wire logic [gpcr_pkg::AW-1:0] S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  // port pins, bit 16*port+pin
  input  wire logic [95:0]           GPIO_IN,
  output logic      [95:0]           GPIO_OUT,
  output logic      [95:0]           GPIO_OE,
  // event link, same clock
  input  wire logic [5:0]            PORT_EVENT_PULSE,
  input  wire logic [95:0]           EVENT_INPUT_DATA
);
  localparam int NP = gpcr_pkg::NPORT;
  localparam int NB = gpcr_pkg::PINS;
  localparam int HB = gpcr_pkg::HALF;

  gpcr_pkg::gpcr_core_t st_ff;
  gpcr_pkg::gpcr_core_t nxt_st;

  logic                       wr_go;
  logic [gpcr_pkg::AW-1:0]    wr_addr;
  logic [31:0]                wr_data;
  logic [3:0]                 wr_strb;
  logic                       wr_ok;
  logic                       rd_go;
  logic [gpcr_pkg::AW-1:0]    rd_addr;
  logic [31:0]                rd_data;
  logic                       rd_ok;
  logic [NP-1:0][NB-1:0]      pin_lvl;

  // address decode shared by the write and read paths
  function automatic gpcr_pkg::gpcr_sel_t gpcr_dec(input logic [gpcr_pkg::AW-1:0] a);
    logic [gpcr_pkg::AW-1:0] ofs;
    ofs = a & (gpcr_pkg::PORT_STRIDE - 12'h001);
    gpcr_dec = gpcr_pkg::GPCR_SEL_NONE;
    if (a < gpcr_pkg::PORT_SPAN) begin
      case (ofs)
        gpcr_pkg::OFS_DIR_OUT: gpcr_dec = gpcr_pkg::GPCR_SEL_DIR_OUT;
        gpcr_pkg::OFS_INPUT:   gpcr_dec = gpcr_pkg::GPCR_SEL_INPUT;
        gpcr_pkg::OFS_SW_SC:   gpcr_dec = gpcr_pkg::GPCR_SEL_SW_SC;
        gpcr_pkg::OFS_EVT_SC:  gpcr_dec = gpcr_pkg::GPCR_SEL_EVT_SC;
        default:               gpcr_dec = gpcr_pkg::GPCR_SEL_NONE;
      endcase
    end else if (a >= gpcr_pkg::PFS_BASE && a <= gpcr_pkg::PFS_LAST) begin
      gpcr_dec = gpcr_pkg::GPCR_SEL_PFS;
    end
    if (a[1:0] != 2'h0) begin
      gpcr_dec = gpcr_pkg::GPCR_SEL_NONE;
    end
  endfunction : gpcr_dec

  // port index of a port register or a function select word
  function automatic logic [2:0] gpcr_port(input logic [gpcr_pkg::AW-1:0] a);
    logic [gpcr_pkg::AW-1:0] idx;
    idx = (a - gpcr_pkg::PFS_BASE) >> 2;
    if (a < gpcr_pkg::PORT_SPAN) begin
      gpcr_port = a[7:5];
    end else begin
      gpcr_port = idx[6:4];
    end
  endfunction : gpcr_port

  // pin index of a function select word
  function automatic logic [3:0] gpcr_pin(input logic [gpcr_pkg::AW-1:0] a);
    logic [gpcr_pkg::AW-1:0] idx;
    idx = (a - gpcr_pkg::PFS_BASE) >> 2;
    gpcr_pin = idx[3:0];
  endfunction : gpcr_pin

  // byte strobes widened to a bit mask
  function automatic logic [31:0] gpcr_lanes(input logic [3:0] s);
    gpcr_lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : gpcr_lanes

  function automatic logic [HB-1:0] gpcr_merge(input logic [HB-1:0] old_v,
                                               input logic [HB-1:0] new_v,
                                               input logic [HB-1:0] en);
    gpcr_merge = (old_v & ~en) | (new_v & en);
  endfunction : gpcr_merge

  gpcr_axil u_axil (
    .clk     (SYS_CLK),
    .rst     (SYS_RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_go   (rd_go),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // pin levels cross into the clock domain
  gpcr_sync #(.W(NP*NB)) u_pin_sync (
    .clk (SYS_CLK),
    .rst (SYS_RST),
    .d   (GPIO_IN),
    .q   (pin_lvl)
  );

  // register writes, software set/clear and event set/clear
  always_comb begin
    gpcr_pkg::gpcr_sel_t wsel;
    logic [2:0]    wport;
    logic [3:0]    wpin;
    logic [31:0]   wm;
    logic [HB-1:0] odr_v;
    logic [HB-1:0] dir_v;
    logic [HB-1:0] pmr_v;
    logic [HB-1:0] set_v;
    logic [HB-1:0] clr_v;
    logic [HB-1:0] msk;
    wsel   = gpcr_dec(wr_addr);
    wport  = gpcr_port(wr_addr);
    wpin   = gpcr_pin(wr_addr);
    wm     = gpcr_lanes(wr_strb);
    odr_v  = '0;
    dir_v  = '0;
    pmr_v  = '0;
    set_v  = '0;
    clr_v  = '0;
    msk    = '0;
    nxt_st = st_ff;
    wr_ok  = wsel != gpcr_pkg::GPCR_SEL_NONE;
    for (int p = 0; p < NP; p++) begin
      msk   = gpcr_pkg::PIN_EXIST[p];
      odr_v = st_ff.odr[p];
      dir_v = st_ff.dir[p];
      pmr_v = st_ff.peripheral_mode_bit[p];
      set_v = '0;
      clr_v = '0;
      if (wr_go && wport == 3'(p)) begin
        case (wsel)
          gpcr_pkg::GPCR_SEL_DIR_OUT: begin
            odr_v = gpcr_merge(odr_v, wr_data[31:HB], wm[31:HB]);
            dir_v = gpcr_merge(dir_v, wr_data[HB-1:0], wm[HB-1:0]);
          end
          gpcr_pkg::GPCR_SEL_SW_SC: begin
            set_v = wr_data[HB-1:0] & wm[HB-1:0];
            clr_v = wr_data[31:HB] & wm[31:HB];
          end
          gpcr_pkg::GPCR_SEL_EVT_SC: begin
            nxt_st.eos[p] = gpcr_merge(st_ff.eos[p], wr_data[HB-1:0], wm[HB-1:0]) & msk;
            nxt_st.eor[p] = gpcr_merge(st_ff.eor[p], wr_data[31:HB], wm[31:HB]) & msk;
          end
          gpcr_pkg::GPCR_SEL_PFS: begin
            if (wm[gpcr_pkg::PFS_ODR_BIT]) begin
              odr_v[wpin] = wr_data[gpcr_pkg::PFS_ODR_BIT];
              dir_v[wpin] = wr_data[gpcr_pkg::PFS_DIR_BIT];
            end
            if (wm[gpcr_pkg::PFS_PMR_BIT]) begin
              pmr_v[wpin] = wr_data[gpcr_pkg::PFS_PMR_BIT];
            end
          end
          default: begin
          end
        endcase
      end
      // software set wins over a clear of the same bit
      odr_v = (odr_v & ~clr_v) | set_v;
      if (PORT_EVENT_PULSE[p]) begin
        odr_v = (odr_v & ~st_ff.eor[p]) | st_ff.eos[p];
        nxt_st.eid[p] = EVENT_INPUT_DATA[p*NB +: NB] & msk;
      end
      nxt_st.odr[p] = odr_v & msk;
      nxt_st.dir[p] = dir_v & msk;
      nxt_st.peripheral_mode_bit[p] = pmr_v & msk;
      nxt_st.oe[p]  = dir_v & ~pmr_v & msk;
    end
  end

  // read data assembly in the cycle the address is taken, answered on the next cycle
  always_comb begin
    gpcr_pkg::gpcr_sel_t rsel;
    logic [2:0] rport;
    logic [3:0] rpin;
    rsel    = gpcr_dec(rd_addr);
    rport   = gpcr_port(rd_addr);
    rpin    = gpcr_pin(rd_addr);
    rd_data = gpcr_pkg::ZERO_WORD;
    rd_ok   = rd_go;
    case (rsel)
      gpcr_pkg::GPCR_SEL_DIR_OUT: begin
        rd_data = {st_ff.odr[rport], st_ff.dir[rport]};
      end
      gpcr_pkg::GPCR_SEL_INPUT: begin
        rd_data = {st_ff.eid[rport], pin_lvl[rport]};
      end
      gpcr_pkg::GPCR_SEL_SW_SC: begin
        rd_data = gpcr_pkg::ZERO_WORD;
      end
      gpcr_pkg::GPCR_SEL_EVT_SC: begin
        rd_data = {st_ff.eor[rport], st_ff.eos[rport]};
      end
      gpcr_pkg::GPCR_SEL_PFS: begin
        rd_data[gpcr_pkg::PFS_ODR_BIT] = st_ff.odr[rport][rpin];
        rd_data[gpcr_pkg::PFS_PIN_BIT] = pin_lvl[rport][rpin];
        rd_data[gpcr_pkg::PFS_DIR_BIT] = st_ff.dir[rport][rpin];
        rd_data[gpcr_pkg::PFS_PMR_BIT] = st_ff.peripheral_mode_bit[rport][rpin];
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign GPIO_OUT = st_ff.odr;
  assign GPIO_OE  = st_ff.oe;
endmodule : gpcr_top

// ---- gpcr_top_test.sv ----
// self-checking bench for the port control register block
`timescale 1ns/1ns
module gpcr_top_test;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} gpcr_note_t;
  logic        clk = 1'h0, rst = 1'h1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0, a;
  logic [31:0] wdata = 32'h0, seed = 32'h0000_0038, v;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [95:0] gin, gout, goe, evbus, ext = 96'h0, evd = 96'h0;
  logic [5:0]  evreq = 6'h00, evp;
  logic [15:0] e, s, g1;
  int          bad_count = 0, check_count = 0, cyc = 0;
  gpcr_note_t  rq[$], n;
  logic [1:0]  bq[$];

  gpcr_top dut (
    .SYS_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe), .PORT_EVENT_PULSE(evp),
    .EVENT_INPUT_DATA(evbus));
  gpcr_pins pins (
    .clk(clk), .pin_out(gout), .pin_oe(goe), .ext_lvl(ext), .pin_in(gin),
    .ev_req(evreq), .ev_dat(evd), .ev_pulse(evp), .ev_bus(evbus));

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] r);
    logic done;
    done = 1'h0;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      done = bvalid && bready;
    end
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    logic done;
    done = 1'h0;
    rq.push_back('{d, m, r});
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      done = rvalid && rready;
    end
    rready <= 1'h0;
  endtask : rd

  // answer watcher: oldest note against each response
  always @(posedge clk) begin
    if (rvalid && rready && rq.size() > 0) begin
      n = rq.pop_front();
      chk(rdata & n.m, n.d & n.m);
      chk({30'h0, rresp}, {30'h0, n.r});
    end
    if (bvalid && bready && bq.size() > 0) chk({30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk({31'h0, |{gout, goe}}, 32'h0);
    rd(12'h000, 32'h0, 32'hFFFF_FFFF, 2'h0);
    $display("reset test done");
    for (int p = 0; p < 6; p++) begin
      e = gpcr_pkg::PIN_EXIST[p];
      a = 12'(p * 32);
      seed = lfsr(seed);
      wr(a, seed, 4'hF, 2'h0);
      chk({16'h0, gout[p*16 +: 16]}, {16'h0, seed[31:16] & e});
      chk({16'h0, goe[p*16 +: 16]}, {16'h0, seed[15:0] & e});
      v = {seed[31:16] & e, seed[15:0] & e};
      seed = lfsr(seed);
      wr(a, seed, 4'h3, 2'h0);
      rd(a, {v[31:16], seed[15:0] & e}, 32'hFFFF_FFFF, 2'h0);
    end
    $display("direction and output test done");
    wr(12'h000, 32'h0000_FFFF, 4'hF, 2'h0);
    wr(12'h008, 32'h0000_0F0F, 4'h3, 2'h0);
    chk({16'h0, gout[15:0]}, 32'h0F0F);
    wr(12'h008, 32'hFFFF_0000, 4'h3, 2'h0);
    wr(12'h008, 32'h0F00_0100, 4'hF, 2'h0);
    wr(12'h008, 32'h0, 4'hF, 2'h0);
    chk({16'h0, gout[15:0]}, 32'h010F);
    rd(12'h008, 32'h0, 32'hFFFF_FFFF, 2'h0);
    wr(12'h0A8, 32'h0000_FFFF, 4'h3, 2'h0);
    chk({16'h0, gout[95:80]}, 32'h00FF);
    $display("set and clear test done");
    wr(12'h00C, 32'h0101_00F0, 4'hF, 2'h0);
    rd(12'h00C, 32'h0101_00F0, 32'hFFFF_FFFF, 2'h0);
    seed = lfsr(seed);
    s = seed[15:0];
    g1 = gout[31:16];
    @(posedge clk);
    evd <= {6{s}};
    evreq <= 6'h3F;
    @(posedge clk);
    evreq <= 6'h00;
    repeat (3) @(posedge clk);
    chk({16'h0, gout[15:0]}, 32'h00FE);
    chk({16'h0, gout[31:16]}, {16'h0, g1});
    rd(12'h004, {s, 16'h0}, 32'hFFFF_0000, 2'h0);
    $display("event test done");
    seed = lfsr(seed);
    ext = {3{seed}};
    wr(12'h040, 32'h0000_FF00, 4'hF, 2'h0);
    wr(12'h044, 32'hFFFF_FFFF, 4'hF, 2'h0);
    chk({goe[47:32], gout[47:32]}, 32'hFF00_0000);
    repeat (3) @(posedge clk);
    rd(12'h044, {16'h0, ext[47:32]}, 32'h0000_00FF, 2'h0);
    $display("pin input test done");
    wr(12'h1D4, 32'h0000_0005, 4'h1, 2'h0);
    chk({30'h0, gout[53], goe[53]}, 32'h3);
    rd(12'h060, 32'h0020_0020, 32'h0020_0020, 2'h0);
    wr(12'h1D4, 32'h0, 4'h3, 2'h0);
    chk({30'h0, gout[53], goe[53]}, 32'h0);
    wr(12'h1D4, 32'h0001_0004, 4'hF, 2'h0);
    chk({31'h0, goe[53]}, 32'h0);
    rd(12'h1D4, 32'h0001_0004, 32'hFFFF_FFFD, 2'h0);
    rd(12'h060, 32'h0000_0020, 32'h0000_0020, 2'h0);
    rd(12'h100, 32'h0000_0004, 32'hFFFF_FFFD, 2'h0);
    rd(12'h27C, 32'h0, 32'hFFFF_FFFF, 2'h0);
    rd(12'h280, 32'h0, 32'hFFFF_FFFF, 2'h2);
    rd(12'h002, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(12'h0C0, 32'hFFFF_FFFF, 4'hF, 2'h2);
    $display("function select test done");
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk({31'h0, |{gout, goe}}, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule : gpcr_top_test
